// ### rtl/nvx_pkg.sv
`default_nettype none
package nvx_pkg;
   // register offsets
   localparam logic [11:0] NVX_OFS_STATE  = 12'hB00;
   localparam logic [11:0] NVX_OFS_ERROR  = 12'hB01;
   localparam logic [11:0] NVX_OFS_RELOAD = 12'hB02;
   localparam logic [11:0] NVX_OFS_SAVE   = 12'hB03;
   // field positions
   localparam int NVX_BIT_BUSY   = 0;
   localparam int NVX_BIT_ERR    = 0;
   localparam int NVX_BIT_UNLOCK = 0;
   localparam int NVX_BIT_RELOAD = 1;
   localparam int NVX_BIT_SAVE   = 0;
   localparam int NVX_BIT_OPCODE = 7;
   // reset values
   localparam logic NVX_RST_UNLOCK = 1'b0;
   // transfer list segment
   localparam logic [11:0] NVX_SEG_BASE = 12'hA00;
   localparam logic [7:0]  NVX_SEG_LAST = 8'hFF;
   // opcode and list phase values (arbitrary encodings)
   localparam logic [7:0]  NVX_OP_UPDATE = 8'h80;
   localparam logic [7:0]  NVX_OP_END    = 8'hFF;
   localparam logic [1:0]  NVX_PH_CMD = 2'h0;
   localparam logic [1:0]  NVX_PH_AHI = 2'h1;
   localparam logic [1:0]  NVX_PH_ALO = 2'h2;

   typedef enum logic [3:0] {
      NVX_IDLE = 4'b0000,
      NVX_LREQ = 4'b0001,
      NVX_LGET = 4'b0010,
      NVX_BREQ = 4'b0011,
      NVX_BGET = 4'b0100,
      NVX_NREQ = 4'b0101,
      NVX_NWT  = 4'b0110,
      NVX_BWR  = 4'b0111,
      NVX_CREQ = 4'b1000,
      NVX_CWT  = 4'b1001,
      NVX_DONE = 4'b1010
   } nvx_state_t;
endpackage
`default_nettype wire

// ### rtl/nvx_ctrl.sv
// Function
// R1: register 0xB00 bit 0 reads one while a save or load runs and zero when done.
// R2: with the routing input set, the busy indication also drives the status pin.
// R3: register 0xB01 bit 0 reads one when a load found bad data, zero when data was good.
// R4: writing one to the reload bit with the boot pin low starts a soft reset and reload; the bit clears itself.
// R5: with the unlock bit at its default zero, every save attempt is blocked.
// R6: with the unlock bit at one, a software save is allowed.
// R7: software waits at least 10 us after one transfer before starting the next.
// R8: writing one to the save bit starts copying the buffer bank into the nonvolatile store.
// R9: the save bit clears itself when the save finishes.
// R10: a list byte with top bit zero is a data transfer of length field plus one, followed by two address bytes, high first.
// R11: a list byte with top bit one is an opcode: apply-shadow (an update pulse) or end-of-data, which ends the transfer.
// R12: the list programmer places an end-of-data opcode in the last byte.
// R13: the busy flag stays set for the whole reload started by soft reset.
// R14: the error flag holds until the next transfer begins.
`default_nettype none
module nvx_ctrl
   import nvx_pkg::*;
#(
   parameter int NVM_AW = 10
) (
   input  wire logic              sys_clk,          // control-port clock
   input  wire logic              rst,              // async reset
   input  wire logic              ce,               // clock enable
   input  wire logic [11:0]       reg_addr,         // register address
   input  wire logic              reg_wr,           // register write strobe
   input  wire logic              reg_rd,           // register read strobe
   input  wire logic [7:0]        reg_wdata,        // write data
   output logic      [7:0]        reg_rdata,        // read data
   input  wire logic              boot_sel_pin,     // boot-select pin
   input  wire logic              status_route_en,  // route busy to pin
   output logic                   status_pin,       // status pin
   output logic      [11:0]       buf_addr,         // buffer bank address
   output logic                   buf_rd,           // buffer read strobe
   output logic                   buf_wr,           // buffer write strobe
   output logic      [7:0]        buf_wdata,        // buffer write data
   input  wire logic [7:0]        buf_rdata,        // buffer data, in the rd cycle
   output logic                   nvm_req,          // store request
   output logic                   nvm_we,           // store write
   output logic      [NVM_AW-1:0] nvm_addr,         // store address
   output logic      [7:0]        nvm_wdata,        // store write data
   input  wire logic [7:0]        nvm_rdata,        // store read data
   input  wire logic              nvm_ack,          // store done
   output logic                   io_update,        // apply shadow pulse
   output logic                   soft_reset        // soft reset pulse
);

   nvx_state_t        st_q, st_d;
   logic              boot_s1_q, boot_s2_q;
   logic              unlock_q, unlock_d;
   logic              save_q, save_d;
   logic              load_q, load_d;
   logic              err_q, err_d;
   logic [1:0]        ph_q, ph_d;
   logic [7:0]        seg_q, seg_d;
   logic [6:0]        cnt_q, cnt_d;
   logic [11:0]       addr_q, addr_d;
   logic [7:0]        sum_q, sum_d;
   logic [7:0]        byte_q, byte_d;
   logic [NVM_AW-1:0] ptr_q, ptr_d;
   logic [7:0]        rdata_d;
   logic [11:0]       baddr_d;
   logic              brd_d, bwr_d, nreq_d, nwe_d, upd_d, srst_d, pin_d;
   logic [7:0]        bwdata_d, nwdata_d;
   logic              busy;

   assign busy = save_q | load_q;

   always_comb begin
      st_d     = st_q;
      unlock_d = unlock_q;
      save_d   = save_q;
      load_d   = load_q;
      err_d    = err_q;
      ph_d     = ph_q;
      seg_d    = seg_q;
      cnt_d    = cnt_q;
      addr_d   = addr_q;
      sum_d    = sum_q;
      byte_d   = byte_q;
      ptr_d    = ptr_q;
      rdata_d  = reg_rdata;
      baddr_d  = buf_addr;
      bwdata_d = buf_wdata;
      nwdata_d = nvm_wdata;
      brd_d    = 1'b0;
      bwr_d    = 1'b0;
      nreq_d   = nvm_req;
      nwe_d    = nvm_we;
      upd_d    = 1'b0;
      srst_d   = 1'b0;
      pin_d    = status_route_en & busy;                        // [R2]

      if (reg_rd) begin
         rdata_d = 8'h00;
         case (reg_addr)
            NVX_OFS_STATE:  rdata_d[NVX_BIT_BUSY] = busy;     // [R1] [R13]
            NVX_OFS_ERROR:  rdata_d[NVX_BIT_ERR] = err_q;     // [R3]
            NVX_OFS_RELOAD: begin
               rdata_d[NVX_BIT_UNLOCK] = unlock_q;
               rdata_d[NVX_BIT_RELOAD] = load_q;
            end
            NVX_OFS_SAVE:   rdata_d[NVX_BIT_SAVE] = save_q;
            default:        rdata_d = 8'h00;
         endcase
      end

      if (reg_wr && reg_addr == NVX_OFS_RELOAD) begin
         unlock_d = reg_wdata[NVX_BIT_UNLOCK];
         if (reg_wdata[NVX_BIT_RELOAD] && !boot_s2_q && !busy) begin
            load_d = 1'b1;                                      // [R4] [R13]
            srst_d = 1'b1;                                      // [R4]
         end
      end
      // save gated by the stored unlock bit, not the one in this write
      if (reg_wr && reg_addr == NVX_OFS_SAVE && reg_wdata[NVX_BIT_SAVE] && !busy) begin
         if (unlock_q) begin
            save_d = 1'b1;                                      // [R6] [R8]
         end
      end                                                       // [R5]

      case (st_q)
         NVX_IDLE: begin
            if (save_d || load_d) begin
               err_d = 1'b0;                                    // [R14]
               seg_d = 8'h00;
               ph_d  = NVX_PH_CMD;
               sum_d = 8'h00;
               ptr_d = '0;
               st_d  = NVX_LREQ;
            end
         end
         NVX_LREQ: begin
            baddr_d = NVX_SEG_BASE | {4'h0, seg_q};
            brd_d   = 1'b1;
            st_d    = NVX_LGET;
         end
         NVX_LGET: begin
            seg_d = seg_q + 8'h01;
            st_d  = NVX_LREQ;
            if (ph_q == NVX_PH_CMD) begin
               if (buf_rdata[NVX_BIT_OPCODE]) begin
                  if (buf_rdata == NVX_OP_UPDATE) begin
                     upd_d = 1'b1;                              // [R11]
                  end else if (buf_rdata == NVX_OP_END) begin
                     st_d = NVX_CREQ;                           // [R11] [R12]
                  end
               end else begin
                  cnt_d = buf_rdata[6:0];                       // [R10]
                  ph_d  = NVX_PH_AHI;
               end
            end else if (ph_q == NVX_PH_AHI) begin
               addr_d = {buf_rdata[3:0], 8'h00};                // [R10]
               ph_d   = NVX_PH_ALO;
            end else begin
               addr_d = {addr_q[11:8], buf_rdata};
               ph_d   = NVX_PH_CMD;
               st_d   = save_q ? NVX_BREQ : NVX_NREQ;
            end
            // list ran off its end without an end opcode
            if (seg_q == NVX_SEG_LAST && st_d == NVX_LREQ) begin
               err_d = load_q;
               st_d  = NVX_DONE;
            end
         end
         NVX_BREQ: begin
            baddr_d = addr_q;
            brd_d   = 1'b1;
            st_d    = NVX_BGET;
         end
         NVX_BGET: begin
            byte_d = buf_rdata;
            st_d   = NVX_NREQ;
         end
         NVX_NREQ: begin
            nreq_d   = 1'b1;
            nwe_d    = save_q;
            nwdata_d = byte_q;
            st_d     = NVX_NWT;
         end
         NVX_NWT: begin
            if (nvm_ack) begin
               nreq_d = 1'b0;
               nwe_d  = 1'b0;
               ptr_d  = ptr_q + 1'b1;
               if (save_q) begin
                  sum_d = sum_q + byte_q;
                  st_d  = NVX_BWR;
               end else begin
                  byte_d = nvm_rdata;
                  sum_d  = sum_q + nvm_rdata;
                  st_d   = NVX_BWR;
               end
            end
         end
         NVX_BWR: begin
            if (load_q) begin
               baddr_d  = addr_q;
               bwdata_d = byte_q;
               bwr_d    = 1'b1;
            end
            addr_d = addr_q + 12'h001;
            cnt_d  = cnt_q - 7'h01;
            st_d   = (cnt_q == 7'h00) ? NVX_LREQ : (save_q ? NVX_BREQ : NVX_NREQ);
         end
         NVX_CREQ: begin
            nreq_d   = 1'b1;
            nwe_d    = save_q;
            nwdata_d = sum_q;
            st_d     = NVX_CWT;
         end
         NVX_CWT: begin
            if (nvm_ack) begin
               nreq_d = 1'b0;
               nwe_d  = 1'b0;
               if (load_q && nvm_rdata != sum_q) begin
                  err_d = 1'b1;                                 // [R3]
               end
               st_d = NVX_DONE;
            end
         end
         NVX_DONE: begin
            save_d = 1'b0;                                      // [R9]
            load_d = 1'b0;                                      // [R1]
            st_d   = NVX_IDLE;
         end
         default: st_d = NVX_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q       <= NVX_IDLE;
         boot_s1_q  <= 1'b0;
         boot_s2_q  <= 1'b0;
         unlock_q   <= NVX_RST_UNLOCK;                          // [R5]
         save_q     <= 1'b0;
         load_q     <= 1'b0;
         err_q      <= 1'b0;
         ph_q       <= NVX_PH_CMD;
         seg_q      <= 8'h00;
         cnt_q      <= 7'h00;
         addr_q     <= 12'h000;
         sum_q      <= 8'h00;
         byte_q     <= 8'h00;
         ptr_q      <= '0;
         reg_rdata  <= 8'h00;
         status_pin <= 1'b0;
         buf_addr   <= 12'h000;
         buf_rd     <= 1'b0;
         buf_wr     <= 1'b0;
         buf_wdata  <= 8'h00;
         nvm_req    <= 1'b0;
         nvm_we     <= 1'b0;
         nvm_addr   <= '0;
         nvm_wdata  <= 8'h00;
         io_update  <= 1'b0;
         soft_reset <= 1'b0;
      end else if (ce) begin
         st_q       <= st_d;
         boot_s1_q  <= boot_sel_pin;
         boot_s2_q  <= boot_s1_q;
         unlock_q   <= unlock_d;
         save_q     <= save_d;
         load_q     <= load_d;
         err_q      <= err_d;
         ph_q       <= ph_d;
         seg_q      <= seg_d;
         cnt_q      <= cnt_d;
         addr_q     <= addr_d;
         sum_q      <= sum_d;
         byte_q     <= byte_d;
         ptr_q      <= ptr_d;
         reg_rdata  <= rdata_d;
         status_pin <= pin_d;
         buf_addr   <= baddr_d;
         buf_rd     <= brd_d;
         buf_wr     <= bwr_d;
         buf_wdata  <= bwdata_d;
         nvm_req    <= nreq_d;
         nvm_we     <= nwe_d;
         nvm_addr   <= ptr_d;
         nvm_wdata  <= nwdata_d;
         io_update  <= upd_d;
         soft_reset <= srst_d;
      end
   end

endmodule
`default_nettype wire

// ### bench/nvx_ctrl_sva.sv
`default_nettype none
module nvx_ctrl_sva
   import nvx_pkg::*;
#(
   parameter int NVM_AW = 10
) (
   input wire logic              sys_clk,         // clock
   input wire logic              rst,             // reset
   input wire logic              ce,              // clock enable
   input wire logic [11:0]       reg_addr,        // address
   input wire logic              reg_wr,          // write
   input wire logic              reg_rd,          // read
   input wire logic [7:0]        reg_wdata,       // wdata
   input wire logic [7:0]        reg_rdata,       // rdata
   input wire logic              status_route_en, // routing
   input wire logic              status_pin,      // pin
   input wire logic              buf_wr,          // bank write
   input wire logic              nvm_req,         // request
   input wire logic              nvm_we,          // store write
   input wire logic [NVM_AW-1:0] nvm_addr,        // store addr
   input wire logic [7:0]        nvm_wdata,       // store data
   input wire logic              nvm_ack,         // store done
   input wire logic              io_update,       // update
   input wire logic              soft_reset       // reload
);
   timeunit 1ns;
   timeprecision 1ps;
   logic unl_q;
   logic unl_d;
   always_comb begin
      unl_d = unl_q;
      if (reg_wr && reg_addr == NVX_OFS_RELOAD) unl_d = reg_wdata[NVX_BIT_UNLOCK];
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) unl_q <= NVX_RST_UNLOCK;
      else if (ce) unl_q <= unl_d;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_pin_route: assert property (status_pin |-> $past(status_route_en))
      else $error("status pin high without routing");
   chk_req_hold: assert property (nvm_req && !nvm_ack |=> nvm_req && $stable({nvm_we, nvm_addr, nvm_wdata}))
      else $error("store request changed before ack");
   chk_req_drop: assert property (nvm_ack |=> !nvm_req)
      else $error("store request held after ack");
   chk_req_gap: assert property ($fell(nvm_req) |=> !nvm_req)
      else $error("store requests too close");
   chk_load_write: assert property (buf_wr |-> $past(nvm_ack, 2) && !$past(nvm_we, 2))
      else $error("bank write without loaded byte");
   chk_update_pulse: assert property (io_update |=> !io_update)
      else $error("update pulse too long");
   chk_reload_pulse: assert property (soft_reset |=> !soft_reset)
      else $error("soft reset pulse too long");
   chk_write_lock: assert property (nvm_req && nvm_we |-> unl_q)
      else $error("store written while locked");
   chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without read");
   chk_err_field: assert property (reg_rd && reg_addr == NVX_OFS_ERROR |=> reg_rdata[7:1] == 7'h00)
      else $error("unused error bits set");
   cover property (soft_reset);
   cover property (nvm_ack && nvm_we);
   cover property (io_update);
endmodule
bind nvx_ctrl nvx_ctrl_sva #(.NVM_AW(NVM_AW)) nvx_ctrl_sva_inst (.sys_clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd,
   .reg_wdata, .reg_rdata, .status_route_en, .status_pin, .buf_wr, .nvm_req, .nvm_we, .nvm_addr, .nvm_wdata,
   .nvm_ack, .io_update, .soft_reset);
`default_nettype wire

// ### bench/nvx_nvm_model.sv
`default_nettype none
module nvx_nvm_model #(
   parameter int NVM_AW = 10
) (
   input  wire logic              sys_clk,   // clock
   input  wire logic              rst,       // reset
   input  wire logic              nvm_req,   // request
   input  wire logic              nvm_we,    // write
   input  wire logic [NVM_AW-1:0] nvm_addr,  // address
   input  wire logic [7:0]        nvm_wdata, // write data
   input  wire logic              slow,      // long answer
   input  wire logic              corrupt,   // bad byte 0
   output logic      [7:0]        nvm_rdata, // read data
   output logic                   nvm_ack    // done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [2**NVM_AW];
   int         cnt;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         nvm_ack <= 1'b0;
         nvm_rdata <= 8'h00;
      end else begin
         nvm_ack <= 1'b0;
         nvm_rdata <= ~nvm_rdata;
         cnt <= 0;
         if (nvm_req && !nvm_ack) begin
            cnt <= cnt + 1;
            if (cnt >= (slow ? 6 : 0)) begin
               cnt <= 0;
               nvm_ack <= 1'b1;
               if (nvm_we) mem[nvm_addr] <= nvm_wdata;
               else nvm_rdata <= mem[nvm_addr] ^ {7'h00, corrupt && nvm_addr == '0};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### bench/nvx_ctrl_test.sv
`default_nettype none
module nvx_ctrl_test
   import nvx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, rst, ce, reg_wr, reg_rd, boot_sel_pin, status_route_en, status_pin, slow, corrupt;
   logic        buf_rd, buf_wr, nvm_req, nvm_we, nvm_ack, io_update, soft_reset;
   logic [11:0] reg_addr, buf_addr;
   logic [7:0]  reg_wdata, reg_rdata, buf_wdata, buf_rdata, nvm_wdata, nvm_rdata, rd_v;
   logic [9:0]  nvm_addr;
   logic [7:0]  bank [4096];
   logic [16:0] lfsr_q = 17'h146ED;
   logic [11:0] ad [5] = '{12'h010, 12'h011, 12'h020, 12'h021, 12'h022};
   logic [7:0]  lst [8] = '{8'h01, 8'h00, 8'h10, NVX_OP_UPDATE, 8'h02, 8'h00, 8'h20, NVX_OP_END};
   int          fails = 0, checks_done = 0, n_upd = 0, n_soft = 0, n_wr = 0, sum = 0;
   logic [7:0]  exp_q [$];
   nvx_ctrl nvx_ctrl_inst (.sys_clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .boot_sel_pin,
      .status_route_en, .status_pin, .buf_addr, .buf_rd, .buf_wr, .buf_wdata, .buf_rdata, .nvm_req, .nvm_we,
      .nvm_addr, .nvm_wdata, .nvm_rdata, .nvm_ack, .io_update, .soft_reset);
   nvx_nvm_model nvx_nvm_model_inst (.sys_clk, .rst, .nvm_req, .nvm_we, .nvm_addr, .nvm_wdata, .slow, .corrupt,
      .nvm_rdata, .nvm_ack);
   always #10 sys_clk = ~sys_clk;
   // bank answers within the buf_rd cycle, the edge that ends it takes the byte
   assign buf_rdata = buf_rd ? bank[buf_addr] : ~bank[buf_addr];
   // buffer bank and event counters
   always @(posedge sys_clk) begin
      if (buf_wr) bank[buf_addr] <= buf_wdata;
      n_upd += int'(io_update);
      n_soft += int'(soft_reset);
      n_wr += int'(nvm_ack && nvm_we);
   end
   function automatic logic [16:0] lfsr_next(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(posedge sys_clk);
      #1 reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge sys_clk);
      #1 {reg_addr, reg_rd} = {a, 1'b1};
      @(posedge sys_clk);
      #1 reg_rd = 1'b0;
      rd_v = reg_rdata;
   endtask
   // poll busy, then keep the host spacing
   task automatic idle();
      for (int i = 0; i < 400 && rd_v[0] !== 1'b0; i++) rd(NVX_OFS_STATE);
      chk(rd_v, 8'h00);
      repeat (500) @(posedge sys_clk);
   endtask
   task automatic reload();
      rd_v = 8'h01;
      wr(NVX_OFS_RELOAD, 8'h02);
      idle();
   endtask
   task automatic give_verdict();
      if (fails == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #1500000 fails++;
      give_verdict();
   end
   initial begin
      {sys_clk, rst, ce, status_route_en} = 4'hF;
      {reg_wr, reg_rd, boot_sel_pin, slow, corrupt, reg_addr, reg_wdata} = '0;
      for (int i = 0; i < 8; i++) bank[12'hA00 + i] = lst[i];
      for (int i = 0; i < 5; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         bank[ad[i]] = lfsr_q[7:0];
         exp_q.push_back(lfsr_q[7:0]);
         sum += lfsr_q[7:0];
      end
      repeat (10) @(posedge sys_clk);
      #1 rst = 1'b0;
      rd(NVX_OFS_RELOAD);
      chk(rd_v, 8'h00);
      rd(12'hB04);
      chk(rd_v, 8'h00);
      wr(NVX_OFS_SAVE, 8'h01);
      repeat (50) @(posedge sys_clk);
      chk(8'(n_wr), 8'h00);
      wr(NVX_OFS_RELOAD, 8'h01);
      rd(NVX_OFS_RELOAD);
      chk(rd_v, 8'h01);
      wr(NVX_OFS_SAVE, 8'h01);
      rd(NVX_OFS_SAVE);
      chk(rd_v, 8'h01);
      chk({7'h00, status_pin}, 8'h01);
      idle();
      rd(NVX_OFS_SAVE);
      chk(rd_v, 8'h00);
      for (int i = 0; i < 5; i++) chk(nvx_nvm_model_inst.mem[i], exp_q[i]);
      chk(nvx_nvm_model_inst.mem[5], 8'(sum));
      for (int i = 0; i < 5; i++) bank[ad[i]] = ~exp_q[i];
      {slow, status_route_en, n_upd, n_soft} = '0;
      slow = 1'b1;
      wr(NVX_OFS_RELOAD, 8'h02);
      rd(NVX_OFS_STATE);
      chk(rd_v, 8'h01);
      chk({7'h00, status_pin}, 8'h00);
      idle();
      chk(8'(n_soft), 8'h01);
      chk(8'(n_upd), 8'h01);
      rd(NVX_OFS_RELOAD);
      chk(rd_v, 8'h00);
      rd(NVX_OFS_ERROR);
      chk(rd_v, 8'h00);
      for (int i = 0; i < 5; i++) chk(bank[ad[i]], exp_q[i]);
      corrupt = 1'b1;
      reload();
      rd(NVX_OFS_ERROR);
      chk(rd_v, 8'h01);
      {corrupt, slow} = 2'b00;
      wr(NVX_OFS_RELOAD, 8'h02);
      rd(NVX_OFS_ERROR);
      chk(rd_v, 8'h00);
      idle();
      boot_sel_pin = 1'b1;
      n_soft = 0;
      repeat (4) @(posedge sys_clk);
      wr(NVX_OFS_RELOAD, 8'h02);
      rd(NVX_OFS_STATE);
      chk(rd_v, 8'h00);
      chk(8'(n_soft), 8'h00);
      // write with the clock enable low must leave the unlock bit untouched
      ce = 1'b0;
      wr(NVX_OFS_RELOAD, 8'h01);
      ce = 1'b1;
      rd(NVX_OFS_RELOAD);
      chk(rd_v, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
